//--- core/wdnmi_pkg.sv
/*
 * Shared constants of the watchdog / non-maskable interrupt timer:
 * register indices, field positions, reset values and divider figures.
 * Assumes one system clock domain; the crystal clock arrives as a pin.
 */
package wdnmi_pkg;
    // ==========================================================
    // register map (index; byte address is four times the index)
    localparam int ADDR_W = 18;
    localparam logic [15:0] CTRL_IDX = 16'hFF07;
    localparam logic [15:0] STAT_IDX = 16'hFF10;
    localparam logic [15:0] MASK_IDX = 16'hFF11;
    localparam logic [15:0] CNT_IDX = 16'hFF12;
    localparam logic [15:0] CPU_IDX = 16'hFF13;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] CNT_ADDR = {CNT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] CPU_ADDR = {CPU_IDX, 2'b00};

    // ==========================================================
    // control register fields
    localparam int RESTART_BIT = 0;
    localparam int ENABLE_BIT = 1;
    localparam logic ENABLE_RST = 1'h1;

    // ==========================================================
    // status / mask fields
    localparam int EV_TIMEOUT = 0;
    localparam int EV_HALT_WAKE = 1;
    localparam int EV_TAKEN = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;

    // ==========================================================
    // cpu status register fields
    localparam int CPU_IMASK_BIT = 0;
    localparam int CPU_PEND_BIT = 1;
    localparam int CPU_HALF_BIT = 2;

    // ==========================================================
    // timing
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_LAST = 10'h3FF;
    localparam int XTAL_HZ = 32768;
    localparam int TICK_HZ = 256;
    localparam int XTAL_DIV = XTAL_HZ / TICK_HZ;
    localparam int DIV_W = 16;
    localparam logic [15:0] NMI_VECTOR = 16'h0100;
endpackage

//--- core/wdnmi_cnt_if.sv
/*
 * Carrier between the register top and the watchdog counter.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface wdnmi_cnt_if
    import wdnmi_pkg::*;
();
    logic tick;
    logic enable;
    logic restart;
    logic overflow;
    logic [CNT_W-1:0] count;

    modport ctl (output tick, output enable, output restart,
        input overflow, input count);
    modport cnt (input tick, input enable, input restart,
        output overflow, output count);
endinterface

//--- core/wdnmi_prescaler.sv
/*
 * Divides the synchronised crystal clock edge stream down to the
 * counting tick of the watchdog.
 * Assumes xtal_rise is a one-cycle pulse per crystal rising edge.
 */
`timescale 1ns/1ps
module wdnmi_prescaler
    import wdnmi_pkg::*;
#(
    parameter logic [DIV_W-1:0] DIV = DIV_W'(XTAL_DIV)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic xtal_rise,
    output logic tick
);
    logic [DIV_W-1:0] div_cnt;

    // ==========================================================
    // free running divider; never cleared by software restart
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (xtal_rise) begin
            if (div_cnt == DIV - DIV_W'(1)) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= div_cnt + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= xtal_rise && (div_cnt == DIV - DIV_W'(1));
        end
    end
endmodule

//--- core/wdnmi_counter.sv
/*
 * The 10-bit watchdog counter and its overflow pulse.
 * Assumes tick is a one-cycle pulse at the counting rate.
 */
`timescale 1ns/1ps
module wdnmi_counter
    import wdnmi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    wdnmi_cnt_if.cnt bus
);
    logic [CNT_W-1:0] count;

    // ==========================================================
    // counter; restart beats a coincident tick
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= CNT_RST;
        end else if (bus.restart) begin
            count <= CNT_RST;
        end else if (bus.tick && bus.enable) begin
            count <= count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus.overflow <= 1'b0;
        end else begin
            bus.overflow <= !bus.restart && bus.tick && bus.enable
                && (count == CNT_LAST);
        end
    end

    assign bus.count = count;
endmodule

//--- core/wdnmi_top.sv
/*
 * Watchdog timer with non-maskable interrupt: APB register slave,
 * crystal synchroniser, interrupt status and the NMI hand-off to the
 * cpu core including its stack-pointer mask state.
 * Assumes an APB master on SYS_CLK and a slow crystal clock pin.
 */
`timescale 1ns/1ps

module wdnmi_top
    import wdnmi_pkg::*;
#(
    parameter logic [DIV_W-1:0] XTAL_DIVIDE = DIV_W'(XTAL_DIV)
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LOW_SPEED_CRYSTAL_CLOCK,
    input wire logic CPU_HALTED,
    input wire logic CPU_DISABLE_FLAG,
    input wire logic FIRST_STACK_POINTER_WR,
    input wire logic SECOND_STACK_POINTER_WR,
    input wire logic CPU_NMI_ACK,
    output logic CPU_NMI_REQ,
    output logic CPU_HALT_RELEASE,
    output logic [15:0] CPU_NMI_VECTOR,
    output logic IRQ
);
    logic [2:0] xtal_sync;
    logic xtal_rise;
    logic watchdog_count_enable;
    logic watchdog_restart_strobe;
    logic nmi_pending;
    logic imask_state;
    logic first_half_seen;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] events;
    logic nmi_take;
    logic wr_access;
    logic setup_phase;
    logic [31:0] next_rdata;
    logic next_slverr;

    wdnmi_cnt_if cnt_bus ();

    // ==========================================================
    // crystal clock pin: two flops, then edge detect on the third
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            xtal_sync <= 3'h0;
        end else begin
            xtal_sync <= {xtal_sync[1:0], LOW_SPEED_CRYSTAL_CLOCK};
        end
    end

    assign xtal_rise = xtal_sync[1] && !xtal_sync[2];

    wdnmi_prescaler #(
        .DIV(XTAL_DIVIDE)
    ) u_prescaler (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .xtal_rise(xtal_rise),
        .tick(cnt_bus.tick)
    );

    wdnmi_counter u_counter (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .bus(cnt_bus.cnt)
    );

    // halt does not gate the tick, so a long halt still times out
    assign cnt_bus.enable = watchdog_count_enable;
    assign cnt_bus.restart = watchdog_restart_strobe;

    // ==========================================================
    // APB: zero wait states, read data captured in the setup cycle
    assign setup_phase = PSEL && !PENABLE;
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign PREADY = PSEL && PENABLE;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_slverr = 1'b0;
        unique case (PADDR)
            CTRL_ADDR: begin
                // restart and upper bits always read back as zero
                next_rdata[ENABLE_BIT] = watchdog_count_enable;
            end
            STAT_ADDR: begin
                next_rdata[EV_W-1:0] = status;
            end
            MASK_ADDR: begin
                next_rdata[EV_W-1:0] = mask;
            end
            CNT_ADDR: begin
                next_rdata[CNT_W-1:0] = cnt_bus.count;
            end
            CPU_ADDR: begin
                next_rdata[CPU_IMASK_BIT] = imask_state;
                next_rdata[CPU_PEND_BIT] = nmi_pending;
                next_rdata[CPU_HALF_BIT] = first_half_seen;
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (setup_phase) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : next_rdata;
            PSLVERR <= next_slverr;
        end
    end

    // ==========================================================
    // watchdog control register
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            watchdog_count_enable <= ENABLE_RST;
        end else if (wr_access && PADDR == CTRL_ADDR) begin
            watchdog_count_enable <= PWDATA[ENABLE_BIT];
        end
    end

    // a written zero is no operation; no storage behind the bit
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            watchdog_restart_strobe <= 1'b0;
        end else begin
            watchdog_restart_strobe <= wr_access && PADDR == CTRL_ADDR
                && PWDATA[RESTART_BIT];
        end
    end

    // ==========================================================
    // cpu mask state: pending until both stack halves written in order
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            imask_state <= 1'b1;
            first_half_seen <= 1'b0;
        end else if (FIRST_STACK_POINTER_WR) begin
            imask_state <= 1'b1;
            first_half_seen <= 1'b1;
        end else if (SECOND_STACK_POINTER_WR && first_half_seen) begin
            imask_state <= 1'b0;
            first_half_seen <= 1'b0;
        end
    end

    // ==========================================================
    // NMI request to the core; disable flag deliberately not looked at
    assign nmi_take = nmi_pending && !imask_state;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            nmi_pending <= 1'b0;
        end else if (cnt_bus.overflow) begin
            nmi_pending <= 1'b1;
        end else if (CPU_NMI_ACK || !watchdog_count_enable) begin
            nmi_pending <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            CPU_NMI_REQ <= 1'b0;
            CPU_HALT_RELEASE <= 1'b0;
            CPU_NMI_VECTOR <= NMI_VECTOR;
        end else begin
            CPU_NMI_REQ <= nmi_take && !CPU_NMI_ACK;
            CPU_HALT_RELEASE <= nmi_take && CPU_HALTED;
            CPU_NMI_VECTOR <= NMI_VECTOR;
        end
    end

    // ==========================================================
    // sticky status, write one to clear; a new event beats the clear
    assign events[EV_TIMEOUT] = cnt_bus.overflow;
    assign events[EV_HALT_WAKE] = nmi_take && CPU_HALTED;
    assign events[EV_TAKEN] = CPU_NMI_ACK && nmi_pending
        && !CPU_DISABLE_FLAG;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            status <= EV_RST;
        end else if (wr_access && PADDR == STAT_ADDR) begin
            status <= (status & ~PWDATA[EV_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            mask <= EV_RST;
        end else if (wr_access && PADDR == MASK_ADDR) begin
            mask <= PWDATA[EV_W-1:0];
        end
    end

    assign IRQ = |(status & mask);
endmodule

//--- dv/wdnmi_cpu_model.sv
/* Behavioural cpu core that takes the watchdog NMI.
   Assumes it shares the system clock with the watchdog. */
`timescale 1ns/1ps
module wdnmi_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic nmi_req,
    input wire logic halt_rel,
    input wire logic [15:0] vector,
    input wire logic halt_cmd,
    input wire logic stack_go,
    input wire logic [3:0] ack_dly,
    output logic halted,
    output logic sp1_wr,
    output logic sp2_wr,
    output logic nmi_ack,
    output logic [7:0] taken
);
    logic masked;
    logic [3:0] wait_n;
    // ==========
    // stack setup: both halves as a pair
    always_ff @(posedge clk) begin
        if (rst) begin
            {sp1_wr, sp2_wr, masked} <= 3'h1;
        end else begin
            sp1_wr <= stack_go;
            sp2_wr <= sp1_wr;
            masked <= masked && !sp2_wr;
        end
    end
    // own disable flag is ignored: the request is masked only until the stack pair is written
    always_ff @(posedge clk) begin
        if (rst || nmi_ack) begin
            nmi_ack <= 1'b0;
            wait_n <= 4'h0;
        end else if (nmi_req && !masked) begin
            wait_n <= wait_n + 4'h1;
            nmi_ack <= wait_n == ack_dly;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) taken <= 8'h0;
        else if (nmi_ack && vector == 16'h0100) taken <= taken + 8'h1;
    end
    always_ff @(posedge clk) begin
        if (rst || halt_rel) halted <= 1'b0;
        else if (halt_cmd) halted <= 1'b1;
    end
endmodule

//--- dv/wdnmi_chk.sv
/* Port checker of the watchdog top.
   Assumes it is bound into wdnmi_top on one clock. */
`timescale 1ns/1ps
module wdnmi_chk
    import wdnmi_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CPU_HALTED,
    input wire logic FIRST_STACK_POINTER_WR,
    input wire logic SECOND_STACK_POINTER_WR,
    input wire logic CPU_NMI_ACK,
    input wire logic CPU_NMI_REQ,
    input wire logic CPU_HALT_RELEASE,
    input wire logic [15:0] CPU_NMI_VECTOR
);
    logic en;
    logic masked;
    logic first;
    wire logic acc = PSEL && PENABLE;
    wire logic wr_ctrl = acc && PWRITE && PADDR == CTRL_ADDR;
    wire logic mapped = PADDR inside
        {CTRL_ADDR, STAT_ADDR, MASK_ADDR, CNT_ADDR, CPU_ADDR};
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // ==========
    // mirrors of enable and stack mask state
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) en <= ENABLE_RST;
        else if (wr_ctrl) en <= PWDATA[ENABLE_BIT];
    end
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || FIRST_STACK_POINTER_WR) begin
            masked <= 1'b1;
            first <= !SYS_RST;
        end else if (SECOND_STACK_POINTER_WR && first) begin
            masked <= 1'b0;
            first <= 1'b0;
        end
    end
    sequence s_rd_ctrl;
        acc && !PWRITE && PADDR == CTRL_ADDR;
    endsequence
    sequence s_wr_off;
        wr_ctrl && !PWDATA[ENABLE_BIT];
    endsequence
    AST_VEC: assert property (CPU_NMI_VECTOR == 16'h0100)
        else $error("nmi vector wrong");
    AST_RDY: assert property (PREADY == acc)
        else $error("pready not zero wait");
    AST_RD: assert property (s_rd_ctrl |-> PRDATA == {30'h0, en, 1'b0})
        else $error("control readback wrong");
    AST_ERR: assert property (acc && !mapped |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    AST_OFF: assert property (s_wr_off |=> ##2 !CPU_NMI_REQ [*2])
        else $error("nmi while disabled");
    AST_MASK: assert property (CPU_NMI_REQ |-> !$past(masked))
        else $error("nmi in stack mask state");
    // enable and mask mirrors exclude the cycle after a legal drop
    AST_STAND: assert property (CPU_NMI_REQ && !CPU_NMI_ACK && !wr_ctrl
        && en && !masked && !FIRST_STACK_POINTER_WR |=> CPU_NMI_REQ)
        else $error("nmi request dropped early");
    AST_HALT: assert property (CPU_HALT_RELEASE |-> $past(CPU_HALTED))
        else $error("halt release without halt");
endmodule
bind wdnmi_top wdnmi_chk i_wdnmi_chk (.*);

//--- dv/watchdog_nmi_timer_test.sv
/* Self-checking bench: APB master, crystal source, cpu model.
   Assumes the design package and the bound checker. */
`timescale 1ns/1ps
module watchdog_nmi_timer_test
    import wdnmi_pkg::*;
;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } wdnmi_row_t;
    // tick every 2 crystal rises, crystal period 6 cycles
    localparam int TICK = 12;
    localparam int LO = 1022 * TICK;
    localparam int HI = 1024 * TICK + 8;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic xtal = 1'b0;
    logic halt_cmd = 1'b0;
    logic stack_go = 1'b0;
    logic [3:0] ack_dly = 4'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q, c0;
    logic pready, pslverr, err, halted, sp1, sp2, ack, req, hrel, irq;
    logic [15:0] vec;
    logic [7:0] taken, t0;
    int fails = 0;
    int n_checks = 0;
    int n;
    wdnmi_row_t rows [8] = '{'{CTRL_ADDR, 1'b0, 32'h0, 32'h2, 1'b0},
        '{CPU_ADDR, 1'b0, 32'h0, 32'h1, 1'b0},
        '{CTRL_ADDR, 1'b1, 32'hF, 32'h0, 1'b0},
        '{CTRL_ADDR, 1'b0, 32'h0, 32'h2, 1'b0},
        '{CTRL_ADDR, 1'b1, 32'h0, 32'h0, 1'b0},
        '{CTRL_ADDR, 1'b0, 32'h0, 32'h0, 1'b0},
        '{18'h0, 1'b0, 32'h0, 32'h0, 1'b1},
        '{CTRL_ADDR, 1'b1, 32'h2, 32'h0, 1'b0}};
    always #2.5 sys_clk = ~sys_clk;
    always #15 xtal = ~xtal;
    wdnmi_top #(.XTAL_DIVIDE(16'h0002)) i_wdnmi_top (.SYS_CLK(sys_clk),
        .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LOW_SPEED_CRYSTAL_CLOCK(xtal),
        .CPU_HALTED(halted), .CPU_DISABLE_FLAG(1'b1),
        .FIRST_STACK_POINTER_WR(sp1), .SECOND_STACK_POINTER_WR(sp2),
        .CPU_NMI_ACK(ack), .CPU_NMI_REQ(req), .CPU_HALT_RELEASE(hrel),
        .CPU_NMI_VECTOR(vec), .IRQ(irq));
    wdnmi_cpu_model i_wdnmi_cpu_model (.clk(sys_clk), .rst(sys_rst),
        .nmi_req(req), .halt_rel(hrel), .vector(vec), .halt_cmd(halt_cmd),
        .stack_go(stack_go), .ack_dly(ack_dly), .halted(halted),
        .sp1_wr(sp1), .sp2_wr(sp2), .nmi_ack(ack), .taken(taken));
    // ==========
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
        input logic [31:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge sys_clk);
            k++;
        end
        if (pready !== 1'b1) begin
            $display("[ERR] pready expected 1 seen %b", pready);
            fails++;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #450000;
        fails++;
        stop_test;
    end
    // ==========
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk("rdata", rows[i].q, q);
            chk("pslverr", rows[i].e, 32'(err));
        end
        apb(CTRL_ADDR, 1'b1, 32'h3);
        repeat (1024 * TICK + 40) @(posedge sys_clk);
        chk("early nmi", 32'h0, 32'(taken));
        apb(STAT_ADDR, 1'b0, 32'h0);
        chk("status", 32'h1, q);
        apb(MASK_ADDR, 1'b1, 32'h1);
        @(negedge sys_clk);
        chk("irq on", 32'h1, 32'(irq));
        apb(STAT_ADDR, 1'b1, 32'h1);
        @(negedge sys_clk);
        chk("irq off", 32'h0, 32'(irq));
        @(posedge sys_clk) stack_go <= 1'b1;
        @(posedge sys_clk) stack_go <= 1'b0;
        for (n = 0; taken !== 8'h1 && n < 50; n++) @(posedge sys_clk);
        chk("nmi taken", 32'h1, 32'(taken));
        @(posedge sys_clk) halt_cmd <= 1'b1;
        ack_dly <= 4'h5;
        @(posedge sys_clk) halt_cmd <= 1'b0;
        apb(CTRL_ADDR, 1'b1, 32'h3);
        for (n = 0; req !== 1'b1 && n < HI + 50; n++) @(posedge sys_clk);
        chk("timeout span", 32'h1, 32'(n >= LO && n <= HI));
        chk("halted at nmi", 32'h1, 32'(halted));
        repeat (20) @(posedge sys_clk);
        chk("halt left", 32'h0, 32'(halted));
        t0 = taken;
        repeat (2) begin
            apb(CTRL_ADDR, 1'b1, 32'h3);
            repeat (10000) @(posedge sys_clk);
        end
        chk("nmi while fed", 32'(t0), 32'(taken));
        apb(CTRL_ADDR, 1'b1, 32'h0);
        apb(CNT_ADDR, 1'b0, 32'h0);
        c0 = q;
        repeat (14000) @(posedge sys_clk);
        apb(CNT_ADDR, 1'b0, 32'h0);
        chk("held count", c0, q);
        chk("nmi while off", 32'(t0), 32'(taken));
        stop_test;
    end
endmodule
